// [rtl/usart_pkg.sv]
// Shared constants and types of the serial frame transmitter
package usart_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_DATA   = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_ENABLE = 5'h08;
	localparam logic [4:0] OFS_SHARED = 5'h0C;
	localparam logic [4:0] OFS_BAUDLO = 5'h10;
	// Status bit positions
	localparam int ST_EMPTY = 0;
	localparam int ST_TXC   = 1;
	localparam int ST_RXC   = 2;
	localparam int ST_FE    = 3;
	localparam int ST_DBL   = 4;
	// Enable control bit positions and shared location select bit
	localparam int EN_TX     = 0;
	localparam int EN_RX     = 1;
	localparam int EN_TX9    = 2;
	localparam int EN_RX9    = 3;
	localparam int EN_SIZE2  = 4;
	localparam int EN_MASTER = 5;
	localparam int SEL_BIT   = 7;
	// Reset values
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] FRAME_RST  = 8'h86;
	localparam logic [3:0] BAUDHI_RST = 4'h0;
	localparam logic [7:0] BAUDLO_RST = 8'h00;
	// Timing
	localparam logic [3:0] DIV_NORMAL = 4'hF;
	localparam logic [3:0] DIV_DOUBLE = 4'h7;
	localparam logic [3:0] HALF_NORMAL = 4'h7;
	localparam logic [3:0] HALF_DOUBLE = 4'h3;
	localparam int FRAME_W = 13;
	// Parity, size and response codes
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD  = 2'h3;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       shared_location_select;
		logic       sync_mode_select;
		logic [1:0] parity_mode_field;
		logic       stop_bit_select;
		logic [1:0] char_size_low;
		logic       clock_polarity;
	} frame_ctl_t;

	// Data bits for a size code; reserved codes fall back to eight
	function automatic logic [3:0] size_bits(input logic [2:0] code);
		if (code == SIZE_NINE)
			return 4'h9;
		else if (code[2])
			return 4'h8;
		else
			return 4'h5 + {2'h0, code[1:0]};
	endfunction : size_bits

	function automatic logic [8:0] size_mask(input logic [3:0] n);
		return 9'h1FF >> (4'h9 - n);
	endfunction : size_mask
endpackage : usart_pkg

// [rtl/baud_tick_gen.sv]
// Baud rate down-counter producing one tick per zero crossing
`timescale 1ns/1ns
module baud_tick_gen (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [11:0] rate_i,
	input  wire logic        reload_i,
	output logic             tick_o
);
	logic [11:0] cnt_r;
	logic        tick_r;
	wire         zero_w = (cnt_r == 12'h000);

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_r  <= 12'h000;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= (zero_w || reload_i) ? rate_i : cnt_r - 12'h001;
			tick_r <= zero_w && !reload_i;
		end
	end
	assign tick_o = tick_r;

	a_tick_reload: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(zero_w && !reload_i) |=> (tick_o && cnt_r == $past(rate_i)))
		else $error("baud counter did not reload on zero");
endmodule : baud_tick_gen

// [rtl/usart_frame_transmitter.sv]
// USART frame transmitter, receiver framing and register slave
// Functional notes
// - Sync mode makes clock pin an output as master, input as slave.
// - Receive samples on the clock edge opposite the transmit change.
// - Polarity clear changes data on rising edge; set on falling.
// - One start, five to nine data, optional parity, one or two stops.
// - Start bit first, then data least significant bit first.
// - Parity bit sits after last data bit, before first stop.
// - After a frame, next frame starts at once or line idles high.
// - One shared format setting for receiver and transmitter.
// - Receiver checks only first stop; zero there flags framing error.
// - Even parity is XOR of data; odd parity is its inverse.
// - Shared location writes control only when top bit is set.
// - Transmit enable hands the transmit pin to the serial output.
// - Data write fills buffer; moved to shifter when idle or frame ends.
// - Shifter sends a frame at baud generator or external clock rate.
// - Unused upper data bits are dropped for short characters.
// - Buffer empty flag set while free, cleared by data write.
// - Complete flag sets when shifter empties, cleared by writing one.
// - Baud counter reloads from rate at zero or low byte write.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module usart_frame_transmitter (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [4:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [4:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic             txd_o,
	output logic             txd_oe_o,
	input  wire logic        rxd_i,
	input  wire logic        xck_i,
	output logic             xck_o,
	output logic             xck_oe_o
);
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

	usart_pkg::frame_ctl_t fctl_r;
	logic [7:0]  ectl_r;
	logic [3:0]  baud_hi_r;
	logic [7:0]  baud_lo_r;
	logic        dbl_r;
	logic        txc_r;
	logic        full_r;
	logic [8:0]  buf_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;
	logic        tick_w;
	logic        xck_r;
	logic [2:0]  xck_sync_r;
	logic [1:0]  rxd_sync_r;
	tx_state_t   tx_state_r;
	logic [12:0] frame_r;
	logic [3:0]  left_r;
	logic [3:0]  tx_pre_r;
	logic        txd_r;
	rx_state_t   rx_state_r;
	logic [3:0]  rx_pre_r;
	logic [3:0]  rx_cnt_r;
	logic [9:0]  rx_bits_r;
	logic [7:0]  rx_data_r;
	logic        rx9_r;
	logic        rxc_r;
	logic        fe_r;

	// Shared frame format decode
	wire [2:0] size_code_w = {ectl_r[usart_pkg::EN_SIZE2],
		fctl_r.char_size_low};
	wire [3:0] nbits_w   = usart_pkg::size_bits(size_code_w);
	wire [8:0] mask_w    = usart_pkg::size_mask(nbits_w);
	wire       par_en_w  = fctl_r.parity_mode_field == usart_pkg::PAR_EVEN
		|| fctl_r.parity_mode_field == usart_pkg::PAR_ODD;
	wire       par_odd_w = fctl_r.parity_mode_field == usart_pkg::PAR_ODD;
	wire       sync_w    = fctl_r.sync_mode_select;
	wire       master_w  = ectl_r[usart_pkg::EN_MASTER];
	wire       tx_en_w   = ectl_r[usart_pkg::EN_TX];
	wire       rx_en_w   = ectl_r[usart_pkg::EN_RX];

	// Register bus decode
	wire wr_w   = awvalid_i && wvalid_i && !bvalid_r;
	wire wr_en_w = wr_w && wstrb_i[0];
	wire rd_w   = arvalid_i && !rvalid_r;
	wire wr_data_w   = wr_en_w && awaddr_i == usart_pkg::OFS_DATA;
	wire wr_status_w = wr_en_w && awaddr_i == usart_pkg::OFS_STATUS;
	wire wr_enable_w = wr_en_w && awaddr_i == usart_pkg::OFS_ENABLE;
	wire wr_shared_w = wr_en_w && awaddr_i == usart_pkg::OFS_SHARED;
	wire wr_baudlo_w = wr_en_w && awaddr_i == usart_pkg::OFS_BAUDLO;
	wire wr_map_w = awaddr_i[1:0] == 2'h0
		&& awaddr_i <= usart_pkg::OFS_BAUDLO;
	wire rd_map_w = araddr_i[1:0] == 2'h0
		&& araddr_i <= usart_pkg::OFS_BAUDLO;
	wire rd_data_w = rd_w && araddr_i == usart_pkg::OFS_DATA;
	wire [7:0] status_w = {3'h0, dbl_r, fe_r, rxc_r, txc_r, !full_r};
	wire [7:0] enable_rd_w = {ectl_r[7:4], rx9_r, ectl_r[2:0]};
	wire [7:0] rd_mux_w =
		araddr_i == usart_pkg::OFS_DATA   ? rx_data_r :
		araddr_i == usart_pkg::OFS_STATUS ? status_w :
		araddr_i == usart_pkg::OFS_ENABLE ? enable_rd_w :
		araddr_i == usart_pkg::OFS_SHARED ? fctl_r :
		araddr_i == usart_pkg::OFS_BAUDLO ? baud_lo_r : 8'h00;

	assign awready_o = wr_w;
	assign wready_o  = wr_w;
	assign bvalid_o  = bvalid_r;
	assign bresp_o   = bresp_r;
	assign arready_o = rd_w;
	assign rvalid_o  = rvalid_r;
	assign rresp_o   = rresp_r;
	assign rdata_o   = rdata_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			bvalid_r <= 1'b0;
			bresp_r  <= usart_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= usart_pkg::RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else begin
			if (wr_w) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_map_w ? usart_pkg::RESP_OKAY
					: usart_pkg::RESP_SLVERR;
			end else if (bready_i)
				bvalid_r <= 1'b0;
			if (rd_w) begin
				rvalid_r <= 1'b1;
				rresp_r  <= rd_map_w ? usart_pkg::RESP_OKAY
					: usart_pkg::RESP_SLVERR;
				rdata_r  <= {24'h000000, rd_mux_w};
			end else if (rready_i)
				rvalid_r <= 1'b0;
		end
	end

	// Control registers; shared location steered by its top bit
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			fctl_r    <= usart_pkg::FRAME_RST;
			ectl_r    <= usart_pkg::ENABLE_RST;
			baud_hi_r <= usart_pkg::BAUDHI_RST;
			baud_lo_r <= usart_pkg::BAUDLO_RST;
			dbl_r     <= 1'b0;
		end else begin
			if (wr_shared_w && wdata_i[usart_pkg::SEL_BIT])
				fctl_r <= wdata_i[7:0];
			else if (wr_shared_w)
				baud_hi_r <= wdata_i[3:0];
			if (wr_enable_w)
				ectl_r <= {wdata_i[7:4], 1'b0, wdata_i[2:0]};
			if (wr_baudlo_w)
				baud_lo_r <= wdata_i[7:0];
			if (wr_status_w)
				dbl_r <= wdata_i[usart_pkg::ST_DBL];
		end
	end

	baud_tick_gen u_baud (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.rate_i   ({baud_hi_r, baud_lo_r}),
		.reload_i (wr_baudlo_w),
		.tick_o   (tick_w)
	);

	// Pin synchronisers and transfer clock edges
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			xck_sync_r <= 3'h0;
			rxd_sync_r <= 2'h3;
			xck_r      <= 1'b0;
		end else begin
			xck_sync_r <= {xck_sync_r[1:0], xck_i};
			rxd_sync_r <= {rxd_sync_r[0], rxd_i};
			if (sync_w && master_w && tick_w)
				xck_r <= !xck_r;
			else if (!(sync_w && master_w))
				xck_r <= fctl_r.clock_polarity;
		end
	end
	wire rxd_w   = rxd_sync_r[1];
	wire rise_w  = master_w ? (tick_w && !xck_r)
		: (xck_sync_r[1] && !xck_sync_r[2]);
	wire fall_w  = master_w ? (tick_w && xck_r)
		: (!xck_sync_r[1] && xck_sync_r[2]);
	wire change_w = fctl_r.clock_polarity ? fall_w : rise_w;
	wire sample_w = fctl_r.clock_polarity ? rise_w : fall_w;
	wire [3:0] div_w  = dbl_r ? usart_pkg::DIV_DOUBLE
		: usart_pkg::DIV_NORMAL;
	wire [3:0] half_w = dbl_r ? usart_pkg::HALF_DOUBLE
		: usart_pkg::HALF_NORMAL;

	assign xck_o    = xck_r;
	assign xck_oe_o = sync_w && master_w;

	// Transmit bit timing
	wire tx_strobe_w = sync_w ? change_w
		: (tick_w && tx_pre_r == div_w);
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			tx_pre_r <= 4'h0;
		else if (tick_w)
			tx_pre_r <= (tx_pre_r == div_w) ? 4'h0 : tx_pre_r + 4'h1;
	end

	// Frame build from buffered character
	wire [8:0] tx_data_w = buf_r & mask_w;
	wire       tx_par_w  = ^tx_data_w ^ par_odd_w;
	wire [3:0] tx_len_w  = 4'h2 + nbits_w + {3'h0, par_en_w}
		+ {3'h0, fctl_r.stop_bit_select};
	logic [12:0] tx_frame_w;
	always_comb begin
		tx_frame_w = 13'h1FFF;
		tx_frame_w[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(nbits_w))
				tx_frame_w[1 + i] = tx_data_w[i];
		end
		if (par_en_w)
			tx_frame_w[nbits_w + 4'h1] = tx_par_w;
	end

	wire tx_last_w = tx_state_r == TX_SHIFT && left_r == 4'h0;
	wire tx_load_w = tx_strobe_w && full_r
		&& (tx_state_r == TX_IDLE || tx_last_w);
	wire tx_done_w = tx_strobe_w && tx_last_w && !full_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tx_state_r <= TX_IDLE;
			frame_r    <= 13'h1FFF;
			left_r     <= 4'h0;
			txd_r      <= 1'b1;
		end else if (tx_strobe_w) begin
			case (tx_state_r)
				TX_SHIFT: begin
					if (left_r != 4'h0) begin
						txd_r   <= frame_r[1];
						frame_r <= {1'b1, frame_r[12:1]};
						left_r  <= left_r - 4'h1;
					end else if (full_r) begin
						txd_r   <= 1'b0;
						frame_r <= tx_frame_w;
						left_r  <= tx_len_w - 4'h1;
					end else begin
						txd_r      <= 1'b1;
						tx_state_r <= TX_IDLE;
					end
				end
				TX_IDLE: begin
					if (full_r) begin
						txd_r      <= 1'b0;
						frame_r    <= tx_frame_w;
						left_r     <= tx_len_w - 4'h1;
						tx_state_r <= TX_SHIFT;
					end
				end
				default: tx_state_r <= TX_IDLE;
			endcase
		end
	end
	assign txd_o    = txd_r;
	assign txd_oe_o = tx_en_w || full_r
		|| tx_state_r == TX_SHIFT;

	// Transmit buffer and flags; hardware set wins over software clear
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			full_r <= 1'b0;
			buf_r  <= 9'h000;
			txc_r  <= 1'b0;
		end else begin
			if (wr_data_w) begin
				full_r <= 1'b1;
				buf_r  <= {ectl_r[usart_pkg::EN_TX9], wdata_i[7:0]};
			end else if (tx_load_w)
				full_r <= 1'b0;
			if (tx_done_w)
				txc_r <= 1'b1;
			else if (wr_status_w && wdata_i[usart_pkg::ST_TXC])
				txc_r <= 1'b0;
		end
	end

	// Receiver framing on the shared format
	wire [3:0] rx_stop_w = nbits_w + {3'h0, par_en_w};
	wire rx_strobe_w = sync_w ? sample_w
		: (tick_w && rx_pre_r == (rx_state_r == RX_START
		? half_w : div_w));
	wire rx_done_w = rx_state_r == RX_DATA && rx_strobe_w
		&& rx_cnt_r == rx_stop_w;
	wire [8:0] rx_word_w = rx_bits_r[8:0] & mask_w;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rx_state_r <= RX_IDLE;
			rx_pre_r   <= 4'h0;
			rx_cnt_r   <= 4'h0;
			rx_bits_r  <= 10'h000;
		end else begin
			if (tick_w)
				rx_pre_r <= rx_strobe_w ? 4'h0 : rx_pre_r + 4'h1;
			case (rx_state_r)
				RX_IDLE: begin
					rx_cnt_r <= 4'h0;
					if (rx_en_w && !rxd_w && sync_w && sample_w)
						rx_state_r <= RX_DATA;
					else if (rx_en_w && !rxd_w && !sync_w) begin
						rx_state_r <= RX_START;
						rx_pre_r   <= 4'h0;
					end
				end
				RX_START: begin
					if (rx_strobe_w)
						rx_state_r <= rxd_w ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rx_strobe_w) begin
						rx_bits_r[rx_cnt_r] <= rxd_w;
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_done_w)
							rx_state_r <= RX_IDLE;
					end
				end
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end

	// Receive result and flags; frame completion wins over a read
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rx_data_r <= 8'h00;
			rx9_r     <= 1'b0;
			rxc_r     <= 1'b0;
			fe_r      <= 1'b0;
		end else if (rx_done_w) begin
			rx_data_r <= rx_word_w[7:0];
			rx9_r     <= rx_word_w[8];
			rxc_r     <= 1'b1;
			fe_r      <= !rxd_w;
		end else if (rd_data_w)
			rxc_r <= 1'b0;
	end

	a_pin_takeover: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		tx_en_w |-> txd_oe_o)
		else $error("transmit pin not driven while enabled");

	a_idle_high: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(tx_state_r == TX_IDLE && !$past(tx_load_w)) |-> txd_o)
		else $error("idle line not high");

	a_start_first: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		tx_load_w |=> (!txd_o && frame_r == $past(tx_frame_w)))
		else $error("frame does not open with start bit");

	a_empty_clear: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		wr_data_w |=> status_w[usart_pkg::ST_EMPTY] == 1'b0)
		else $error("buffer empty flag not cleared by write");

	a_complete_set: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		tx_done_w |=> txc_r && txd_o)
		else $error("complete flag not set after last stop");

	a_master_clock: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(sync_w && master_w) |-> xck_oe_o ##1
		(!(sync_w && master_w) || xck_oe_o))
		else $error("transfer clock pin not driven as master");

	a_frame_length: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		tx_load_w |=> left_r == 4'h1 + $past(nbits_w)
		+ {3'h0, $past(par_en_w)}
		+ {3'h0, $past(fctl_r.stop_bit_select)})
		else $error("frame length mismatch");

	a_parity_slot: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(tx_load_w && par_en_w) |->
		tx_frame_w[nbits_w + 4'h1] == (^tx_data_w ^ par_odd_w))
		else $error("parity bit wrong or misplaced");

	a_sync_change: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(sync_w && $changed(txd_r)) |-> $past(change_w))
		else $error("sync data changed off its clock edge");

	a_frame_error: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		rx_done_w |=> (fe_r == !$past(rxd_w) && rxc_r))
		else $error("framing error not taken from first stop");
endmodule : usart_frame_transmitter

// [verif/serial_peer.sv]
// Remote serial peer: captures frames from the transmit line
`timescale 1ns/1ns
module serial_peer (
	input  wire logic       clk_i,
	input  wire logic       txd_i,
	input  wire logic       sync_i,
	input  wire logic [7:0] bit_clks_i,
	input  wire logic [3:0] len_i,
	output logic            rxd_o,
	output logic            xck_o,
	output logic [12:0]     frame_o,
	output int              n_frames_o
);
	initial begin
		rxd_o = 1'b1;
		xck_o = 1'b0;
		frame_o = 13'h0000;
		n_frames_o = 0;
	end

	// Async capture at mid-bit; no wait after last stop, so back to back
	// frames are not missed
	always @(negedge txd_i) begin
		if (!sync_i) begin
			repeat (bit_clks_i / 2) @(posedge clk_i);
			frame_o[0] = txd_i;
			for (int i = 1; i < len_i; i++) begin
				repeat (bit_clks_i) @(posedge clk_i);
				frame_o[i] = txd_i;
			end
			n_frames_o++;
		end
	end

	// Drives one frame onto the receive line, then idles it a bit time
	task automatic drive_async(input logic [12:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_o = f[i];
			repeat (bit_clks_i) @(posedge clk_i);
		end
		rxd_o = 1'b1;
		repeat (bit_clks_i) @(posedge clk_i);
	endtask : drive_async

	// Slave transfer clock, runs only for one frame, off the system phase
	task automatic run_sync(input logic pol, input int len);
		int got;
		got = 0;
		xck_o = pol;
		#87;
		for (int k = 0; k < len + 4 && got < len; k++) begin
			xck_o = ~pol;
			#80;
			xck_o = pol;
			if (got > 0 || txd_i == 1'b0) begin
				frame_o[got] = txd_i;
				got++;
			end
			#80;
		end
		n_frames_o++;
	endtask : run_sync
endmodule : serial_peer

// [verif/usart_frame_transmitter_tb.sv]
// Self-checking bench of the serial frame transmitter
`timescale 1ns/1ns
module usart_frame_transmitter_tb;
	logic        clk_i    = 1'b0;
	logic        resetn_i = 1'b0;
	logic [4:0]  awaddr   = 5'h00;
	logic        awvalid  = 1'b0;
	logic [31:0] wdata    = 32'h00000000;
	logic [3:0]  wstrb    = 4'hF;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic [4:0]  araddr   = 5'h00;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic        sync_m   = 1'b0;
	logic [7:0]  bit_clks = 8'h10;
	logic [3:0]  len      = 4'hA;
	logic [7:0]  cur_en   = 8'h00;
	logic [3:0]  nb       = 4'h8;
	logic [1:0]  cur_par  = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        txd, txd_oe, rxd, transfer_clock_pin, xck_out, xck_oe;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [12:0] frame;
	int          n_frames;
	int          n_mismatch = 0;
	int          compares   = 0;
	int          cyc        = 0;

	usart_frame_transmitter uut (
		.clk_i(clk_i), .resetn_i(resetn_i),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
		.wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
		.wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
		.bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
		.rvalid_o(rvalid), .rready_i(rready), .txd_o(txd),
		.txd_oe_o(txd_oe), .rxd_i(rxd), .xck_i(transfer_clock_pin), .xck_o(xck_out),
		.xck_oe_o(xck_oe)
	);

	serial_peer peer (
		.clk_i(clk_i), .txd_i(txd), .sync_i(sync_m), .bit_clks_i(bit_clks),
		.len_i(len), .rxd_o(rxd), .xck_o(transfer_clock_pin), .frame_o(frame),
		.n_frames_o(n_frames)
	);

	always #10 clk_i = ~clk_i;

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		output logic [1:0] r);
		@(posedge clk_i);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge clk_i); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge clk_i); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		v = {rresp, rdata[13:0]};
		rready <= 1'b0;
	endtask : rd

	// Rate, mode and format all set before any data write
	task automatic cfg(input logic [2:0] code, input logic [1:0] par,
		input logic stp, snc, dbl, mst, pol, input logic [7:0] rate);
		logic [1:0] r;
		cur_en   = {2'b00, mst, code[2], 2'b00, 2'b11};
		nb       = (code == 3'h7) ? 4'h9 : 4'h5 + {1'b0, code};
		cur_par  = par;
		len      = 4'h2 + nb + {3'h0, par[1]} + {3'h0, stp};
		bit_clks = (dbl ? 8'h08 : 8'h10) * (rate + 8'h01);
		sync_m   = snc;
		// High nibble first, so the low byte write reloads the new high nibble with the old low byte
		wr(usart_pkg::OFS_SHARED, 8'h00, r);
		wr(usart_pkg::OFS_BAUDLO, rate, r);
		wr(usart_pkg::OFS_STATUS, {3'b000, dbl, 4'h0}, r);
		wr(usart_pkg::OFS_ENABLE, cur_en, r);
		wr(usart_pkg::OFS_SHARED, {1'b1, snc, par, stp, code[1:0], pol}, r);
	endtask : cfg

	task automatic send(input logic [8:0] d);
		logic [1:0] r;
		wr(usart_pkg::OFS_ENABLE, cur_en | {5'h00, d[8], 2'b00}, r);
		wr(usart_pkg::OFS_DATA, d[7:0], r);
	endtask : send

	function automatic logic [12:0] exp_frame(input logic [3:0] n,
		input logic [1:0] par, input logic [8:0] d);
		logic [12:0] f;
		logic        p;
		f    = 13'h1FFF;
		f[0] = 1'b0;
		p    = par[0];
		for (int k = 0; k < n; k++) begin
			f[k+1] = d[k];
			p = p ^ d[k];
		end
		if (par[1])
			f[n+1] = p;
		return f;
	endfunction : exp_frame

	task automatic chk_frame(input logic [8:0] d);
		logic [12:0] m;
		m = 13'h1FFF >> (4'hD - len);
		chk("frame", {3'h0, exp_frame(nb, cur_par, d) & m}, {3'h0, frame & m});
	endtask : chk_frame

	task automatic wait_to(input int n);
		for (int i = 0; i < 3000 && n_frames < n; i++) @(posedge clk_i);
	endtask : wait_to

	task automatic xfer(input logic [8:0] d);
		int k;
		k = n_frames;
		send(d);
		wait_to(k + 1);
		chk_frame(d);
		repeat (bit_clks) @(posedge clk_i);
	endtask : xfer

	task automatic t_reset();
		logic [15:0] v;
		logic [1:0]  r;
		rd(usart_pkg::OFS_STATUS, v);
		chk("status", 16'h0001, v);
		rd(usart_pkg::OFS_SHARED, v);
		chk("frame ctl", 16'h0086, v);
		chk("txd idle", 16'h0001, {14'h0, txd_oe, txd});
		wr(usart_pkg::OFS_SHARED, 8'h05, r);
		rd(usart_pkg::OFS_SHARED, v);
		chk("shared select", 16'h0086, v);
		rd(5'h14, v);
		chk("unmapped rd", 16'h8000, v);
		wr(5'h14, 8'hFF, r);
		chk("unmapped wr", 16'h0002, {14'h0, r});
		$display("test reset done");
	endtask : t_reset

	task automatic t_formats();
		logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		logic [1:0] pars  [5] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3};
		logic [8:0] dats  [5] = '{9'h1F5, 9'h0AB, 9'h0FF, 9'h0C3, 9'h155};
		for (int k = 0; k < 5; k++) begin
			cfg(codes[k], pars[k], k[0], 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
			xfer(dats[k]);
		end
		chk("tx oe", 16'h0001, {15'h0, txd_oe});
		$display("test formats done");
	endtask : t_formats

	task automatic t_b2b();
		logic [15:0] v;
		logic [1:0]  r;
		int          k;
		cfg(3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
		wr(usart_pkg::OFS_STATUS, 8'h02, r);
		k = n_frames;
		send(9'h03C);
		for (int i = 0; i < 100 && txd !== 1'b0; i++) @(posedge clk_i);
		send(9'h0A5);
		rd(usart_pkg::OFS_STATUS, v);
		chk("status busy", 16'h0000, v);
		wait_to(k + 1);
		chk_frame(9'h03C);
		wait_to(k + 2);
		chk_frame(9'h0A5);
		repeat (16) @(posedge clk_i);
		rd(usart_pkg::OFS_STATUS, v);
		chk("status done", 16'h0003, v);
		wr(usart_pkg::OFS_STATUS, 8'h02, r);
		rd(usart_pkg::OFS_STATUS, v);
		chk("txc clear", 16'h0001, v);
		$display("test back to back done");
	endtask : t_b2b

	task automatic t_speed();
		cfg(3'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		xfer(9'h05A);
		cfg(3'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02);
		xfer(9'h0E1);
		$display("test speed done");
	endtask : t_speed

	task automatic t_rx();
		logic [15:0] v;
		logic [12:0] f;
		cfg(3'h3, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
		f = exp_frame(4'h8, 2'h2, 9'h0C6);
		peer.drive_async(f, 11);
		rd(usart_pkg::OFS_STATUS, v);
		chk("rx flags", 16'h0004, v & 16'h000C);
		rd(usart_pkg::OFS_DATA, v);
		chk("rx data", 16'h00C6, v);
		// First stop bit low must raise the framing error
		f[10] = 1'b0;
		peer.drive_async(f, 11);
		rd(usart_pkg::OFS_STATUS, v);
		chk("rx fe", 16'h000C, v & 16'h000C);
		$display("test receive done");
	endtask : t_rx

	task automatic t_sync();
		logic tog;
		for (int p = 0; p < 2; p++) begin
			cfg(3'h3, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0, p[0], 8'h00);
			chk("xck slave", 16'h0000, {15'h0, xck_oe});
			send(9'h0B4);
			peer.run_sync(p[0], len);
			chk_frame(9'h0B4);
		end
		cfg(3'h3, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
		chk("xck master", 16'h0001, {15'h0, xck_oe});
		@(negedge clk_i) tog = xck_out;
		@(negedge clk_i);
		chk("xck toggle", {15'h0, !tog}, {15'h0, xck_out});
		$display("test sync done");
	endtask : t_sync

	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_formats();
		t_b2b();
		t_speed();
		t_rx();
		t_sync();
		tally_and_finish();
	end
endmodule : usart_frame_transmitter_tb
